// ---- stc_edge_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser with a rising edge detector behind the second stage.
module stc_edge_sync
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic asyncIn,
    output logic edgePulse
);

    // First stage; read only by the second stage.
    logic meta_reg;
    // Second stage, the synchronised level.
    logic sync_reg;
    // Delayed synchronised level for the edge detector.
    logic last_reg;

    // Synchroniser chain and edge history.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= asyncIn;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // One pulse per rising edge of the synchronised level.
    assign edgePulse = sync_reg & ~last_reg;

endmodule
`default_nettype wire

// ---- stc_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side: sweep engines reporting completion, and an external trigger source.
module stc_far_model
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] sweepStart,
    input wire logic [3:0] sweepHold,
    input wire logic [7:0] doneLat,
    input wire logic extFire,
    output logic [3:0] sweepDone,
    output logic extTrigIn
);
    logic [7:0] cntReg [4]; // Cycles left in each engine's sweep.
    logic [2:0] extCntReg; // Cycles left of the trigger line's high time.
    // Engines run down a cycle, freeze while held, and pulse done at the end.
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 4; i++)
        begin
            sweepDone[i] <= 1'b0;
            if (!nrst)
                cntReg[i] <= 8'h00;
            else if (sweepStart[i])
                cntReg[i] <= doneLat;
            else if (cntReg[i] != 8'h00 && !sweepHold[i])
            begin
                cntReg[i] <= cntReg[i] - 8'h01;
                sweepDone[i] <= (cntReg[i] == 8'h01);
            end
        end
    end
    // Each request raises the trigger line for four cycles; it idles low.
    always @(posedge clk_sys)
    begin
        if (!nrst)
            extCntReg <= 3'h0;
        else if (extFire)
            extCntReg <= 3'h4;
        else if (extCntReg != 3'h0)
            extCntReg <= extCntReg - 3'h1;
    end
    assign extTrigIn = (extCntReg != 3'h0);
endmodule
`default_nettype wire

// ---- stc_pkg.sv ----
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types of the sweep trigger control.
package stc_pkg;

    // Number of sweep engines served by the block.
    localparam int NUM_SWEEPS = 4;

    // Sweep channel indices on every per-sweep vector.
    localparam int CH_RF_FREQ = 0;
    localparam int CH_LF_FREQ = 1;
    localparam int CH_RF_LEVEL = 2;
    localparam int CH_COMBINED = 3;

    // Index of the immediate trigger aimed at all sweeps but the combined one on the immediate vector.
    localparam int IMM_ALL = 3;

    // Target codes of a source selection write.
    localparam logic [2:0] TGT_RF_FREQ = 3'h0;
    localparam logic [2:0] TGT_LF_FREQ = 3'h1;
    localparam logic [2:0] TGT_RF_LEVEL = 3'h2;
    localparam logic [2:0] TGT_ALL = 3'h3;
    localparam logic [2:0] TGT_COMBINED = 3'h4;

    // Source name codes as sent by the host; both naming sets are listed.
    localparam logic [2:0] NAME_AUTO = 3'h0;
    localparam logic [2:0] NAME_IMMEDIATE = 3'h1;
    localparam logic [2:0] NAME_SINGLE = 3'h2;
    localparam logic [2:0] NAME_BUS = 3'h3;
    localparam logic [2:0] NAME_EXTERNAL = 3'h4;
    localparam logic [2:0] NAME_EXT_START_STOP = 3'h5;

    // Normalised trigger source of one sweep.
    typedef enum logic [1:0] {
        SRC_AUTO,
        SRC_SINGLE,
        SRC_EXTERNAL,
        SRC_EXT_START_STOP
    } stc_src_e;

    // Phase of the external start/stop source.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_RUN,
        PH_HALTED
    } stc_phase_e;

    // Source selected after reset.
    localparam stc_src_e SRC_RESET = SRC_AUTO;

endpackage

// ---- stc_sweep_trigger.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - No arm step; triggers always armed.
// - Own source per sweep, plus a selection for all sweeps but the combined one.
// - Accept both source naming sets.
// - Automatic source restarts sweep after completion.
// - Single source runs one cycle per event.
// - Step mode advances one step per event.
// - External edge starts sweep, mode picks step.
// - Start/stop: start, halt, restart, repeat.
// - Combined sweep own source, holds pair.
// - Immediate trigger needs single source, auto mode.
// - Immediate-all fires every active sweep but the combined one.
// - LF trigger command needs single, auto.
// - Immediate trigger equals the execute command; here it acts only in auto mode, while execute also steps.
////////////////////////////////////////////////////////////////////////////////
module stc_sweep_trigger
#(
    parameter int NUM_SWEEPS = stc_pkg::NUM_SWEEPS
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    // Host writes a source selection; one-cycle strobe.
    input wire logic srcWrValid,
    // Which selection is written: RF freq, LF freq, RF level, all or combined.
    input wire logic [2:0] srcWrTarget,
    // Source name code, either naming set.
    input wire logic [2:0] srcWrName,
    // Bus trigger command; one-cycle strobe.
    input wire logic busTrigCmd,
    // Execute command per sweep; one-cycle strobes.
    input wire logic [NUM_SWEEPS-1:0] execCmd,
    // Immediate trigger commands: RF freq, LF freq, RF level, all three of these sweeps.
    input wire logic [3:0] immCmd,
    // Dedicated LF sweep trigger command; one-cycle strobe.
    input wire logic lfTrigCmd,
    // Sweep mode per sweep: high for step, low for auto.
    input wire logic [NUM_SWEEPS-1:0] stepMode,
    // Sweep switched on per sweep.
    input wire logic [NUM_SWEEPS-1:0] sweepActive,
    // Sweep engine finished a full cycle; one-cycle pulses.
    input wire logic [NUM_SWEEPS-1:0] sweepDone,
    // External trigger input.
    input wire logic extTrigIn,
    // Start a full cycle from the start value; one-cycle pulses.
    output logic [NUM_SWEEPS-1:0] sweepStart,
    // Advance by one step; one-cycle pulses.
    output logic [NUM_SWEEPS-1:0] sweepStep,
    // Freeze at the present value; level.
    output logic [NUM_SWEEPS-1:0] sweepHold,
    // Sweep cycle in progress; level.
    output logic [NUM_SWEEPS-1:0] sweepBusy,
    // Selected source per sweep, two bits each.
    output logic [2*NUM_SWEEPS-1:0] srcSelOut
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Tells whether a name code is one of the known source names.
    function automatic logic isKnownName(input logic [2:0] name);
        isKnownName = (name <= stc_pkg::NAME_EXT_START_STOP);
    endfunction

    // Folds both naming sets onto one internal source.
    function automatic stc_pkg::stc_src_e decodeName(input logic [2:0] name);
        case (name)
            stc_pkg::NAME_AUTO: decodeName = stc_pkg::SRC_AUTO;
            stc_pkg::NAME_IMMEDIATE: decodeName = stc_pkg::SRC_AUTO;
            stc_pkg::NAME_SINGLE: decodeName = stc_pkg::SRC_SINGLE;
            stc_pkg::NAME_BUS: decodeName = stc_pkg::SRC_SINGLE;
            stc_pkg::NAME_EXTERNAL: decodeName = stc_pkg::SRC_EXTERNAL;
            stc_pkg::NAME_EXT_START_STOP: decodeName = stc_pkg::SRC_EXT_START_STOP;
            default: decodeName = stc_pkg::SRC_RESET;
        endcase
    endfunction

    // Tells whether a selection write reaches a given sweep channel.
    function automatic logic writeHits(input logic [2:0] target, input int ch);
        logic hit;
        hit = 1'b0;
        case (ch)
            stc_pkg::CH_RF_FREQ:
                hit = (target == stc_pkg::TGT_RF_FREQ) || (target == stc_pkg::TGT_ALL);
            stc_pkg::CH_LF_FREQ:
                hit = (target == stc_pkg::TGT_LF_FREQ) || (target == stc_pkg::TGT_ALL);
            stc_pkg::CH_RF_LEVEL:
                hit = (target == stc_pkg::TGT_RF_LEVEL) || (target == stc_pkg::TGT_ALL);
            stc_pkg::CH_COMBINED:
                hit = (target == stc_pkg::TGT_COMBINED);
            default:
                hit = 1'b0;
        endcase
        writeHits = hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // External trigger synchronisation.

    // One pulse per synchronised rising edge of the external trigger.
    logic extEdge;

    // The pin is brought into the clock domain before any channel looks at it.
    stc_edge_sync u_ext_sync
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .asyncIn(extTrigIn),
        .edgePulse(extEdge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-sweep channels.

    // Selected source per sweep.
    stc_pkg::stc_src_e srcReg [NUM_SWEEPS];
    // Start/stop phase per sweep.
    stc_pkg::stc_phase_e phaseReg [NUM_SWEEPS];
    // Sweep cycle in progress per sweep.
    logic [NUM_SWEEPS-1:0] busy_reg;
    // Registered start, step and hold outputs.
    logic [NUM_SWEEPS-1:0] start_reg;
    logic [NUM_SWEEPS-1:0] step_reg;
    logic [NUM_SWEEPS-1:0] hold_reg;
    // Combinational decisions per sweep for the coming edge.
    logic [NUM_SWEEPS-1:0] start_next;
    logic [NUM_SWEEPS-1:0] step_next;
    // Source selection changes in this cycle per sweep.
    logic [NUM_SWEEPS-1:0] srcWrite;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_SWEEPS; ch++)
        begin : g_ch
            // Source of this sweep is single with auto mode.
            logic singleAuto;
            // Immediate trigger aimed at this sweep, gated.
            logic immHit;
            // Trigger event of the single source.
            logic singleEvent;

            // A write lands only for a known name and a matching target.
            assign srcWrite[ch] = srcWrValid && isKnownName(srcWrName)
                && writeHits(srcWrTarget, ch);

            // Source selection register; each sweep keeps its own.
            always_ff @(posedge clk_sys)
            begin
                if (!nrst)
                begin
                    srcReg[ch] <= stc_pkg::SRC_RESET;
                end
                else if (srcWrite[ch])
                begin
                    srcReg[ch] <= decodeName(srcWrName);
                end
            end

            assign singleAuto = (srcReg[ch] == stc_pkg::SRC_SINGLE) && !stepMode[ch];

            // Immediate commands fire only with single source and auto mode.
            if (ch == stc_pkg::CH_COMBINED)
            begin : g_imm_none
                // The combined sweep has no immediate command of its own.
                assign immHit = 1'b0;
            end
            else if (ch == stc_pkg::CH_LF_FREQ)
            begin : g_imm_lf
                // The LF sweep also answers its dedicated trigger command.
                assign immHit = singleAuto
                    && (immCmd[ch] || immCmd[stc_pkg::IMM_ALL] || lfTrigCmd);
            end
            else
            begin : g_imm_rf
                // Plain immediate or the all-sweeps immediate.
                assign immHit = singleAuto
                    && (immCmd[ch] || immCmd[stc_pkg::IMM_ALL]);
            end

            // Bus trigger and execute commands act alike; immediate commands count only with auto mode.
            assign singleEvent = (srcReg[ch] == stc_pkg::SRC_SINGLE)
                && (busTrigCmd || execCmd[ch] || immHit);

            // Decides start and step pulses for this sweep; an inactive sweep or a
            // source change swallows the event, a busy cycle only a single or external start.
            always_comb
            begin
                start_next[ch] = 1'b0;
                step_next[ch] = 1'b0;
                if (sweepActive[ch] && !srcWrite[ch])
                begin
                    case (srcReg[ch])
                        stc_pkg::SRC_AUTO:
                        begin
                            // Condition always met; restart once the cycle ends.
                            start_next[ch] = !busy_reg[ch] && !start_reg[ch];
                        end
                        stc_pkg::SRC_SINGLE:
                        begin
                            if (singleEvent)
                            begin
                                // Step mode moves one step, auto mode runs a cycle.
                                step_next[ch] = stepMode[ch];
                                start_next[ch] = !stepMode[ch] && !busy_reg[ch];
                            end
                        end
                        stc_pkg::SRC_EXTERNAL:
                        begin
                            if (extEdge)
                            begin
                                // The sweep mode chooses single cycle or step.
                                step_next[ch] = stepMode[ch];
                                start_next[ch] = !stepMode[ch] && !busy_reg[ch];
                            end
                        end
                        stc_pkg::SRC_EXT_START_STOP:
                        begin
                            // Start from idle or restart from a halt.
                            if (extEdge && (phaseReg[ch] != stc_pkg::PH_RUN))
                            begin
                                start_next[ch] = 1'b1;
                            end
                            // Back-to-back repetition while running.
                            else if (phaseReg[ch] == stc_pkg::PH_RUN && !extEdge
                                && !busy_reg[ch] && !start_reg[ch])
                            begin
                                start_next[ch] = 1'b1;
                            end
                        end
                        default:
                        begin
                            start_next[ch] = 1'b0;
                        end
                    endcase
                end
            end

            // Start/stop phase: each external edge moves one phase on.
            always_ff @(posedge clk_sys)
            begin
                if (!nrst)
                begin
                    phaseReg[ch] <= stc_pkg::PH_IDLE;
                end
                else if (srcWrite[ch] || !sweepActive[ch]
                    || srcReg[ch] != stc_pkg::SRC_EXT_START_STOP)
                begin
                    // Leaving the source or the sweep forgets the phase.
                    phaseReg[ch] <= stc_pkg::PH_IDLE;
                end
                else if (extEdge)
                begin
                    case (phaseReg[ch])
                        stc_pkg::PH_IDLE: phaseReg[ch] <= stc_pkg::PH_RUN;
                        stc_pkg::PH_RUN: phaseReg[ch] <= stc_pkg::PH_HALTED;
                        stc_pkg::PH_HALTED: phaseReg[ch] <= stc_pkg::PH_RUN;
                        default: phaseReg[ch] <= stc_pkg::PH_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Cycle tracking and outputs.

    // Busy is set by a start and cleared by the engine's done pulse; a start
    // in the same cycle as a done wins, so no new cycle goes unseen.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            busy_reg <= '0;
        end
        else
        begin
            busy_reg <= start_next | (busy_reg & ~sweepDone & sweepActive & ~srcWrite);
        end
    end

    // Start and step pulses are registered for one cycle each.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            start_reg <= '0;
            step_reg <= '0;
        end
        else
        begin
            start_reg <= start_next;
            step_reg <= step_next;
        end
    end

    // Hold stands while a start/stop sweep sits in its halted phase, keeping
    // the present frequency, or frequency and level pair.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            hold_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_SWEEPS; i++)
            begin
                hold_reg[i] <= sweepActive[i] && !srcWrite[i]
                    && srcReg[i] == stc_pkg::SRC_EXT_START_STOP
                    && ((phaseReg[i] == stc_pkg::PH_RUN && extEdge)
                    || (phaseReg[i] == stc_pkg::PH_HALTED && !extEdge));
            end
        end
    end

    // Selected sources are shown to the host, two bits per sweep.
    always_comb
    begin
        srcSelOut = '0;
        for (int i = 0; i < NUM_SWEEPS; i++)
        begin
            srcSelOut[2*i +: 2] = srcReg[i];
        end
    end

    assign sweepStart = start_reg;
    assign sweepStep = step_reg;
    assign sweepHold = hold_reg;
    assign sweepBusy = busy_reg;

endmodule
`default_nettype wire

// ---- stc_sweep_trigger_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Checker of the sweep trigger control; it sees only the top ports.
module stc_sweep_trigger_checker
#(
    parameter int NUM_SWEEPS = stc_pkg::NUM_SWEEPS
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic srcWrValid,
    input wire logic [2:0] srcWrTarget,
    input wire logic [2:0] srcWrName,
    input wire logic busTrigCmd,
    input wire logic [NUM_SWEEPS-1:0] execCmd,
    input wire logic [3:0] immCmd,
    input wire logic lfTrigCmd,
    input wire logic [NUM_SWEEPS-1:0] stepMode,
    input wire logic [NUM_SWEEPS-1:0] sweepActive,
    input wire logic [NUM_SWEEPS-1:0] sweepDone,
    input wire logic extTrigIn,
    input wire logic [NUM_SWEEPS-1:0] sweepStart,
    input wire logic [NUM_SWEEPS-1:0] sweepStep,
    input wire logic [NUM_SWEEPS-1:0] sweepHold,
    input wire logic [NUM_SWEEPS-1:0] sweepBusy,
    input wire logic [2*NUM_SWEEPS-1:0] srcSelOut
);
    // All properties sample on the system clock and sleep during reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    property p_name_bus;
        srcWrValid && srcWrTarget == stc_pkg::TGT_LF_FREQ && srcWrName == stc_pkg::NAME_BUS
            |=> srcSelOut[3:2] == stc_pkg::SRC_SINGLE;
    endproperty
    a_name_bus: assert property (p_name_bus) else $error("bus name gave no single source");
    property p_all_ext;
        srcWrValid && srcWrTarget == stc_pkg::TGT_ALL && srcWrName == stc_pkg::NAME_EXTERNAL
            |=> srcSelOut[5:0] == 6'h2A;
    endproperty
    a_all_ext: assert property (p_all_ext) else $error("all-sweeps write missed a channel");
    property p_auto_restart;
        srcSelOut[1:0] == stc_pkg::SRC_AUTO && sweepDone[0] && sweepActive[0] && !stepMode[0]
            |-> ##[1:3] (sweepStart[0] || srcSelOut[1:0] != stc_pkg::SRC_AUTO);
    endproperty
    a_auto_restart: assert property (p_auto_restart) else $error("auto sweep not restarted");
    property p_single_quiet;
        srcSelOut[1:0] == stc_pkg::SRC_SINGLE && $stable(srcSelOut[1:0]) && !execCmd[0]
            && !busTrigCmd && !immCmd[0] && !immCmd[3] |=> !sweepStart[0];
    endproperty
    a_single_quiet: assert property (p_single_quiet) else $error("start without trigger");
    property p_step;
        execCmd[0] && srcSelOut[1:0] == stc_pkg::SRC_SINGLE && stepMode[0] && sweepActive[0]
            && !srcWrValid |=> sweepStep[0] && !sweepStart[0];
    endproperty
    a_step: assert property (p_step) else $error("step mode gave no single step");
    property p_imm_gate;
        immCmd[0] && stepMode[0] && srcSelOut[1:0] == stc_pkg::SRC_SINGLE && !execCmd[0]
            && !busTrigCmd |=> !sweepStep[0];
    endproperty
    a_imm_gate: assert property (p_imm_gate) else $error("immediate acted in step mode");
    property p_lf_trig;
        lfTrigCmd && srcSelOut[3:2] == stc_pkg::SRC_SINGLE && !stepMode[1] && sweepActive[1]
            && !sweepBusy[1] && !srcWrValid |=> sweepStart[1];
    endproperty
    a_lf_trig: assert property (p_lf_trig) else $error("LF trigger did not start");
    property p_ext_start;
        $rose(extTrigIn) && srcSelOut[1:0] == stc_pkg::SRC_EXTERNAL && !stepMode[0]
            && sweepActive[0] && !sweepBusy[0] && !srcWrValid |-> ##[2:4] sweepStart[0];
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("external edge did not start");
    property p_hold_quiet;
        sweepHold[0] |-> !sweepStart[0];
    endproperty
    a_hold_quiet: assert property (p_hold_quiet) else $error("start while halted");
    property p_restart;
        $fell(sweepHold[0]) && $stable(srcSelOut[1:0]) |-> sweepStart[0];
    endproperty
    a_restart: assert property (p_restart) else $error("release without restart");
endmodule
bind stc_sweep_trigger stc_sweep_trigger_checker #(.NUM_SWEEPS(NUM_SWEEPS)) u_chk (.*);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the sweep trigger control.
module tb;
    logic clk_sys, nrst, srcWrValid, busTrigCmd, lfTrigCmd, extFire, extTrigIn;
    logic [2:0] srcWrTarget, srcWrName;
    logic [3:0] execCmd, immCmd, stepMode, sweepActive, sweepDone;
    logic [3:0] sweepStart, sweepStep, sweepHold, sweepBusy;
    logic [7:0] srcSelOut, doneLat;
    logic [7:0] startCnt [4] = '{default: 8'h00}, stepCnt [4] = '{default: 8'h00}; // Tallies.
    logic [7:0] startBase [4], stepBase [4]; // Tallies at the last rebase.
    logic [1:0] nameMap [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3}; // Name to source.
    int error_cnt, checks_done;
    stc_sweep_trigger dut (.*);
    stc_far_model far (.*);
    ////////////////////////////////////////////////////////////////////////////
    // The 20 MHz system clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Tally every start and step pulse per channel.
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (sweepStart[i] === 1'b1) startCnt[i] <= startCnt[i] + 8'h01;
            if (sweepStep[i] === 1'b1) stepCnt[i] <= stepCnt[i] + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic rebase();
        startBase = startCnt;
        stepBase = stepCnt;
    endtask
    // Writes one source selection as a one-cycle strobe.
    task automatic wr_src(input logic [2:0] tgt, input logic [2:0] name);
        @(posedge clk_sys);
        srcWrValid <= 1'b1;
        srcWrTarget <= tgt;
        srcWrName <= name;
        @(posedge clk_sys);
        srcWrValid <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Issues command strobes for one cycle; extFire asks the source for an edge.
    task automatic fire(input logic [3:0] ex, input logic [3:0] im, input logic lf,
                        input logic bus, input logic ext);
        @(posedge clk_sys);
        execCmd <= ex;
        immCmd <= im;
        lfTrigCmd <= lf;
        busTrigCmd <= bus;
        extFire <= ext;
        @(posedge clk_sys);
        execCmd <= 4'h0;
        immCmd <= 4'h0;
        lfTrigCmd <= 1'b0;
        busTrigCmd <= 1'b0;
        extFire <= 1'b0;
    endtask
    // Waits, under a bound, until no sweep is busy, then checks the tallies.
    task automatic expect_pulses(input string what, input logic [3:0] sMask,
                                 input logic [3:0] tMask);
        int n;
        n = 0;
        tick(6);
        while (sweepBusy !== 4'h0 && n < 500)
        begin
            tick(1);
            n++;
        end
        if (n == 500)
        begin
            check("busy wait", 8'h00, {4'h0, sweepBusy});
            close_out();
        end
        tick(2);
        for (int i = 0; i < 4; i++)
        begin
            check({what, " start"}, {7'h00, sMask[i]}, startCnt[i] - startBase[i]);
            check({what, " step"}, {7'h00, tMask[i]}, stepCnt[i] - stepBase[i]);
        end
        rebase();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        {nrst, srcWrValid, busTrigCmd, lfTrigCmd, extFire} = 5'h00;
        {srcWrTarget, srcWrName, execCmd, immCmd, stepMode} = 18'h0;
        sweepActive = 4'hF;
        doneLat = 8'h05;
        {error_cnt, checks_done} = 0;
        tick(4);
        nrst <= 1'b1;
        tick(1);
        check("reset source", 8'h00, srcSelOut);
        rebase();
        tick(60);
        check("auto repeat", 8'h01, {7'h00, startCnt[0] - startBase[0] > 8'h05});
        for (int i = 0; i < 7; i++)
        begin
            wr_src(stc_pkg::TGT_LF_FREQ, 3'(i));
            check("lf source", {6'h00, nameMap[i < 6 ? i : 5]}, {6'h00, srcSelOut[3:2]});
        end
        wr_src(3'h7, stc_pkg::NAME_SINGLE);
        check("bad target", 8'h0C, srcSelOut);
        wr_src(stc_pkg::TGT_ALL, stc_pkg::NAME_EXTERNAL);
        check("all external", 8'h2A, srcSelOut);
        wr_src(stc_pkg::TGT_COMBINED, stc_pkg::NAME_EXT_START_STOP);
        check("combined source", 8'hEA, srcSelOut);
        stepMode <= 4'h0;
        wr_src(stc_pkg::TGT_ALL, stc_pkg::NAME_SINGLE);
        wr_src(stc_pkg::TGT_COMBINED, stc_pkg::NAME_BUS);
        check("all single", 8'h55, srcSelOut);
        sweepActive <= 4'h7;
        doneLat <= 8'h14;
        rebase();
        expect_pulses("settle", 4'h0, 4'h0);
        for (int c = 0; c < 4; c++)
        begin
            fire(4'(1 << c), 4'h0, 1'b0, 1'b0, 1'b0);
            expect_pulses("exec", 4'(7 & (1 << c)), 4'h0);
            fire(4'h0, 4'(1 << c), 1'b0, 1'b0, 1'b0);
            expect_pulses("immediate", 4'(c < 3 ? 1 << c : 7), 4'h0);
        end
        fire(4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
        expect_pulses("bus trigger", 4'h7, 4'h0);
        fire(4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        expect_pulses("lf trigger", 4'h2, 4'h0);
        stepMode <= 4'h3;
        fire(4'h1, 4'h0, 1'b0, 1'b0, 1'b0);
        fire(4'h0, 4'h1, 1'b0, 1'b0, 1'b0);
        fire(4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
        fire(4'h2, 4'h0, 1'b0, 1'b0, 1'b0);
        expect_pulses("step mode", 4'h0, 4'h3);
        stepMode <= 4'h0;
        wr_src(stc_pkg::TGT_RF_FREQ, stc_pkg::NAME_EXTERNAL);
        fire(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
        expect_pulses("external", 4'h1, 4'h0);
        stepMode <= 4'h1;
        fire(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
        expect_pulses("external step", 4'h0, 4'h1);
        stepMode <= 4'h0;
        doneLat <= 8'h03;
        wr_src(stc_pkg::TGT_RF_FREQ, stc_pkg::NAME_EXT_START_STOP);
        rebase();
        fire(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
        tick(60);
        check("run repeat", 8'h01, {7'h00, startCnt[0] - startBase[0] > 8'h05});
        fire(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
        tick(6);
        check("halted", 8'h01, {7'h00, sweepHold[0]});
        rebase();
        tick(40);
        check("halted quiet", 8'h00, startCnt[0] - startBase[0]);
        fire(4'h0, 4'h0, 1'b0, 1'b0, 1'b1);
        tick(6);
        check("restarted", 8'h00, {7'h00, sweepHold[0]});
        check("restart", 8'h01, {7'h00, startCnt[0] != startBase[0]});
        nrst <= 1'b0;
        tick(3);
        nrst <= 1'b1;
        tick(1);
        check("second reset", 8'h00, srcSelOut);
        close_out();
    end
endmodule
`default_nettype wire
